/* File: core/bsh_pkg.sv */
/*
 * Package for the bridge status half register block: register offset,
 * field positions, reset values and fixed read values.
 * Assumes a 32-bit AHB-Lite slave with word-aligned single transfers.
 */
package bsh_pkg;

    localparam logic [11:0] CSW_OFFSET        = 12'h004;

    localparam int RCA_BIT    = 28;
    localparam int SCA_BIT    = 27;
    localparam int SELT_HI    = 26;
    localparam int SELT_LO    = 25;
    localparam int MDP_BIT    = 24;
    localparam int BTB_BIT    = 23;
    localparam int RSV22_BIT  = 22;
    localparam int HSC_BIT    = 21;
    localparam int CAPL_BIT   = 20;
    localparam int INTP_BIT   = 19;
    localparam int RSV_HI     = 18;
    localparam int RSV_LO     = 11;
    localparam int PRE_BIT    = 6;

    localparam logic       CAPL_VALUE    = 1'b1;
    localparam logic       PRE_RESET     = 1'b0;
    localparam logic       FLAG_RESET    = 1'b0;
    localparam logic [1:0] SELT_VALUE    = 2'h0;
    localparam logic [7:0] RSV_VALUE     = 8'h00;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD    = 3'b010;
    localparam int         NUM_FLAGS     = 3;

endpackage

/* File: core/bsh_w1c_flag.sv */
/*
 * Write-one-to-clear sticky flag.
 * Assumes set and clear strobes are single-cycle and synchronous to clk_i.
 */
module bsh_w1c_flag (
    input  wire logic clk_i,    // Core clock
    input  wire logic srst_i,   // Sync reset, active high
    input  wire logic set_i,    // Hardware event
    input  wire logic clr_i,    // Software write of one
    output logic      flag_o    // Sticky flag
);
    import bsh_pkg::*;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flag_o <= FLAG_RESET;
        end else if (set_i) begin
            flag_o <= 1'b1;          // Event beats a coinciding clear
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end

endmodule

/* File: core/bsh_csr.sv */
/*
 * Command/status word of a PCIe bridge: upper status flags plus the
 * poison-response enable, reached over AHB-Lite.
 * Assumes single word transfers and event pulses synchronous to clk_i.
 */
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
// How it works
// - Received completer-abort completion sets flag bit 28; write one clears it.
// - Sending a completer-abort completion sets flag bit 27; write one clears.
// - Select-timing, back-to-back and high-speed bits always read zero.
// - Poisoned completion received sets data-poison flag when enable is on.
// - Poisoning an outgoing write sets data-poison flag when enable is on.
// - With the enable off the data-poison flag never sets.
// - Bit 22 and bits 18 to 11 read zero.
// - Capability-list bit reads fixed one.
// - Interrupt-pending bit always reads zero.
// - Poison-response enable is read-write, reset zero.
module bsh_csr
    import bsh_pkg::*;
(
    input  wire logic        clk_i,          // Core clock, 20 MHz
    input  wire logic        srst_i,         // Sync reset, active high
    input  wire logic        hsel_i,         // Slave select
    input  wire logic [11:0] haddr_i,        // Byte address
    input  wire logic [1:0]  htrans_i,       // Transfer type
    input  wire logic        hwrite_i,       // Write when high
    input  wire logic [2:0]  hsize_i,        // Transfer size
    input  wire logic [31:0] hwdata_i,       // Write data
    input  wire logic        hready_i,       // Bus ready
    output logic [31:0]      hrdata_o,       // Read data
    output logic             hreadyout_o,    // Always ready
    output logic             hresp_o,        // Always OKAY
    input  wire logic        cpl_ca_rx_i,    // Completer-abort completion received
    input  wire logic        cpl_ca_tx_i,    // Completer-abort completion sent
    input  wire logic        cpl_poison_rx_i,// Poisoned completion received
    input  wire logic        wr_poison_tx_i, // Outgoing write poisoned
    output logic             poison_resp_en_o // Poison-response enable
);

    logic        wr_pend_q;
    logic        hit_d;
    logic        wr_strobe;
    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flag_clr;
    logic [NUM_FLAGS-1:0] flag_val;
    logic [31:0] rd_word;

    localparam int FLAG_POS [NUM_FLAGS] = '{RCA_BIT, SCA_BIT, MDP_BIT};

    assign hit_d = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ)
                && (hsize_i == HSIZE_WORD) && (haddr_i == CSW_OFFSET);

    // Write address phase captured; data lands in the next cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_pend_q <= 1'b0;
        end else begin
            wr_pend_q <= hit_d && hwrite_i;
        end
    end

    assign wr_strobe = wr_pend_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            poison_resp_en_o <= PRE_RESET;
        end else if (wr_strobe) begin
            poison_resp_en_o <= hwdata_i[PRE_BIT];
        end
    end

    assign flag_set[0] = cpl_ca_rx_i;
    assign flag_set[1] = cpl_ca_tx_i;
    // Gate on the enable so no poisoned traffic sets it while off
    assign flag_set[2] = poison_resp_en_o
                       && (cpl_poison_rx_i || wr_poison_tx_i);

    generate
        for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
            // Only a written one clears
            assign flag_clr[i] = wr_strobe && hwdata_i[FLAG_POS[i]];
            bsh_w1c_flag u_flag (
                .clk_i  (clk_i),
                .srst_i (srst_i),
                .set_i  (flag_set[i]),
                .clr_i  (flag_clr[i]),
                .flag_o (flag_val[i])
            );
        end
    endgenerate

    always_comb begin
        rd_word                   = 32'h0000_0000;
        rd_word[RCA_BIT]          = flag_val[0];
        rd_word[SCA_BIT]          = flag_val[1];
        rd_word[MDP_BIT]          = flag_val[2];
        rd_word[SELT_HI:SELT_LO]  = SELT_VALUE;
        rd_word[BTB_BIT]          = 1'b0;
        rd_word[HSC_BIT]          = 1'b0;
        rd_word[RSV22_BIT]        = 1'b0;
        rd_word[RSV_HI:RSV_LO]    = RSV_VALUE;
        rd_word[CAPL_BIT]         = CAPL_VALUE;
        rd_word[INTP_BIT]         = 1'b0;
        rd_word[PRE_BIT]          = poison_resp_en_o;
    end

    // Read data registered at the address phase, ready for the data phase
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ) && !hwrite_i) begin
            hrdata_o <= hit_d ? rd_word : 32'h0000_0000;
        end
    end

    // Zero wait states; errors are never signalled
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

endmodule

/* File: tb/bsh_csr_props.sv */
/* Checker for the bsh_csr read word and its flag set paths.
 * Assumes hready_i follows hreadyout_o; sees only top ports. */
module bsh_csr_props
    import bsh_pkg::*;
(
    input wire logic        clk_i, srst_i, hsel_i, hwrite_i, poison_resp_en_o,
    input wire logic        cpl_ca_rx_i, cpl_ca_tx_i, cpl_poison_rx_i, wr_poison_tx_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic [2:0]  hsize_i,
    input wire logic [31:0] hrdata_o
);
    wire logic rd = hsel_i && htrans_i == HTRANS_NONSEQ && !hwrite_i
        && haddr_i == CSW_OFFSET && hsize_i == HSIZE_WORD;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Event pulse, then a read one cycle after
    sequence ev_rd(e); e ##1 rd; endsequence
    rsv_zero_a: assert property (rd |=> hrdata_o[RSV_HI:RSV_LO] == RSV_VALUE
        && !hrdata_o[RSV22_BIT]) else $error("reserved bits set");
    fixed_zero_a: assert property (rd |=> hrdata_o[26:25] == SELT_VALUE
        && hrdata_o[23] == 1'b0 && hrdata_o[21] == 1'b0 && hrdata_o[19] == 1'b0)
        else $error("fixed bits set");
    cap_one_a: assert property (rd |=> hrdata_o[CAPL_BIT] == CAPL_VALUE)
        else $error("capability bit low");
    rx_abort_a: assert property (ev_rd(cpl_ca_rx_i) |=> hrdata_o[RCA_BIT])
        else $error("rx abort flag clear");
    tx_abort_a: assert property (ev_rd(cpl_ca_tx_i) |=> hrdata_o[SCA_BIT])
        else $error("tx abort flag clear");
    rx_poison_a: assert property (ev_rd(cpl_poison_rx_i && poison_resp_en_o)
        |=> hrdata_o[MDP_BIT]) else $error("poison flag clear");
    tx_poison_a: assert property (ev_rd(wr_poison_tx_i && poison_resp_en_o)
        |=> hrdata_o[MDP_BIT]) else $error("poison flag clear");
    en_reset_a: assert property ($past(srst_i) |-> !poison_resp_en_o)
        else $error("enable set after reset");
endmodule
bind bsh_csr bsh_csr_props u_props (.*);

/* File: tb/bsh_evt_src.sv */
/* Event source standing for the PCIe transaction layer.
 * Assumes kicks change just after a rising edge of clk_i. */
module bsh_evt_src (
    input  wire logic       clk_i,         // Core clock
    input  wire logic [3:0] kick_i,        // Bench request per event kind
    output logic      [3:0] pulse_o = 4'h0 // One-cycle event pulses
);
    always @(posedge clk_i) pulse_o <= kick_i;
endmodule

/* File: tb/bsh_csr_tb.sv */
/* Bench for bsh_csr: AHB-Lite master, event source, queued read checks.
 * Assumes the checker is bound in from its own file. */
module bsh_csr_tb
    import bsh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 0, srst_i = 1, hsel_i = 0, hwrite_i = 0, rd_ph = 0, rca, sca, mdp, en;
    logic [11:0] haddr_i = 0;
    logic [1:0]  htrans_i = 0;
    logic [2:0]  hsize_i = 0;
    logic [3:0]  kick = 0;
    logic [31:0] hwdata_i = 0, d, hrdata_o, exp_q[$];
    wire logic   hreadyout_o, hresp_o, poison_resp_en_o, hready_i = hreadyout_o;
    wire logic   cpl_ca_rx_i, cpl_ca_tx_i, cpl_poison_rx_i, wr_poison_tx_i;
    integer      seed = 32'he778_3358, num_errors = 0, cmp_count = 0;
    bsh_csr u_dut (.*);
    bsh_evt_src u_src (.clk_i(clk_i), .kick_i(kick),
        .pulse_o({cpl_ca_rx_i, cpl_ca_tx_i, cpl_poison_rx_i, wr_poison_tx_i}));
    initial forever #25 clk_i = ~clk_i;
    task automatic complete_run();
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic step();
        int n = 0;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) begin
            if (++n > 16) begin
                num_errors++;
                complete_run();
            end
            @(posedge clk_i);
        end
    endtask
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] wd);
        {hsel_i, htrans_i, hwrite_i, haddr_i, hsize_i} <= {1'b1, HTRANS_NONSEQ, w, a, HSIZE_WORD};
        step();
        {hsel_i, htrans_i, hwdata_i, rd_ph} <= {3'b000, wd, !w};
        step();
        rd_ph <= 0;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] v);
        exp_q.push_back(v);
        xfer(0, a, 0);
    endtask
    function automatic logic [31:0] expw();
        return {3'b0, rca, sca, 2'b0, mdp, 3'b0, CAPL_VALUE, 13'b0, en, 6'b0};
    endfunction
    task automatic chk(logic [31:0] seen, logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            num_errors++;
            $display("mismatch command_status_word exp %h seen %h", want, seen);
        end
    endtask
    always @(posedge clk_i) if (rd_ph === 1'b1) chk(hrdata_o, exp_q.pop_front());
    initial begin
        {rca, sca, mdp, en} = 4'h0;
        repeat (8) @(posedge clk_i);
        srst_i <= 0;
        @(posedge clk_i);
        rd(CSW_OFFSET, 32'h0010_0000);
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            {d[RCA_BIT], d[SCA_BIT], d[MDP_BIT], d[PRE_BIT]} = {3'b111, i[0]};
            xfer(1, CSW_OFFSET, d);
            {rca, sca, mdp, en} = {3'b000, i[0]};
            kick <= 4'h8 >> i[2:1];
            @(posedge clk_i);
            kick <= 0;
            @(posedge clk_i);
            if (i[2:1] == 0) rca = 1;
            else if (i[2:1] == 1) sca = 1;
            else mdp = en;
            rd(CSW_OFFSET, expw());
            {d[RCA_BIT], d[SCA_BIT], d[MDP_BIT]} = 3'b000;
            xfer(1, CSW_OFFSET, d);
            xfer(1, 12'h008, 32'hFFFF_FFFF);
            rd(12'h008, 32'h0000_0000);
            rd(CSW_OFFSET, expw());
        end
        complete_run();
    end
endmodule
